/* viu_regs.vh */
`ifndef VIU_REGS_VH
`define VIU_REGS_VH
// request lines gathered by the unit
`define VIU_NUM_LINES 32
// width of a line index
`define VIU_IDX_W 5
// priority level width, 0 is most urgent
`define VIU_PRIO_W 4
// service address width
`define VIU_ADDR_W 32
// gpio edge pins: port 0 and port 2, 32 each
`define VIU_NUM_PINS 64
// line shared with external interrupt line three
`define VIU_EXT3_LINE 5'd17
// edge select encoding per pin
`define VIU_EDGE_RISE 0
`define VIU_EDGE_FALL 1
// reset values
`define VIU_RST_ENABLE 32'h0000_0000
`define VIU_RST_FAST 32'h0000_0000
`define VIU_RST_PRIO 4'hf
`define VIU_RST_ADDR 32'h0000_0000
`endif

/* viu_pin_edge.v */
`include "viu_regs.vh"
// one pin: synchronise, detect chosen edges, hold a sticky flag until cleared
module viu_pin_edge (
   clk,
   reset,
   pin,
   rise_en,
   fall_en,
   clr,
   flag
);
   input  wire clk;      // system clock
   input  wire reset;    // async, active high
   input  wire pin;      // raw pin level
   input  wire rise_en;  // catch rising edges
   input  wire fall_en;  // catch falling edges
   input  wire clr;      // software clear pulse
   output wire flag;     // sticky edge flag

   reg meta_q;   // first sync stage, read only by sync_q
   reg sync_q;   // second sync stage
   reg prev_q;   // last synchronised level
   reg flag_q;   // sticky flag
   reg [1:0] arm_q;  // edges since reset; prev_q is real once it reaches 3
   wire hit;

   // edges are judged only on synchronised levels; held off until the chain
   // has filled, so a pin idling high cannot fake a rising edge after reset
   assign hit = (arm_q == 2'd3) &
                ((rise_en & sync_q & ~prev_q) | (fall_en & ~sync_q & prev_q));

   // sync chain and sticky flag; a new edge wins over a clear
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
         flag_q <= 1'b0;
         arm_q  <= 2'b00;
      end else begin
         if (arm_q != 2'd3)
            arm_q <= arm_q + 2'd1;
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
         if (hit)
            flag_q <= 1'b1;
         else if (clr)
            flag_q <= 1'b0;
      end
   end

   assign flag = flag_q;
endmodule // viu_pin_edge

/* viu_req_sync.v */
`include "viu_regs.vh"
// two-stage synchroniser for the request lines from peripherals
module viu_req_sync (
   clk,
   reset,
   req_in,
   req_out
);
   input  wire                       clk;     // system clock
   input  wire                       reset;   // async, active high
   input  wire [`VIU_NUM_LINES-1:0]  req_in;  // raw request levels
   output wire [`VIU_NUM_LINES-1:0]  req_out; // synchronised levels

   reg [`VIU_NUM_LINES-1:0] meta_q;  // first stage, read only by stage two
   reg [`VIU_NUM_LINES-1:0] sync_q;  // second stage

   // plain two-flop chain per line
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= {`VIU_NUM_LINES{1'b0}};
         sync_q <= {`VIU_NUM_LINES{1'b0}};
      end else begin
         meta_q <= req_in;
         sync_q <= meta_q;
      end
   end

   assign req_out = sync_q;
endmodule // viu_req_sync

/* viu_vectored_irq_unit.v */
`include "viu_regs.vh"
module viu_vectored_irq_unit (
   clk,
   reset,
   irq_lines,
   line_enable,
   fast_select,
   line_prio,
   line_addr,
   gpio_pins,
   gpio_rise_en,
   gpio_fall_en,
   gpio_clr,
   gpio_flags,
   fast_interrupt_request,
   normal_interrupt_request,
   fast_pending,
   vector_addr,
   vector_valid,
   vector_line
);
   input  wire                                      clk;             // 10 MHz clock
   input  wire                                      reset;           // async, active high
   input  wire [`VIU_NUM_LINES-1:0]                 irq_lines;       // one per peripheral
   input  wire [`VIU_NUM_LINES-1:0]                 line_enable;     // per-line enable
   input  wire [`VIU_NUM_LINES-1:0]                 fast_select;     // 1 = fast class
   input  wire [`VIU_NUM_LINES*`VIU_PRIO_W-1:0]     line_prio;       // packed priorities
   input  wire [`VIU_NUM_LINES*`VIU_ADDR_W-1:0]     line_addr;       // packed addresses
   input  wire [`VIU_NUM_PINS-1:0]                  gpio_pins;       // port 0 low, port 2 high
   input  wire [`VIU_NUM_PINS-1:0]                  gpio_rise_en;    // rising edge enables
   input  wire [`VIU_NUM_PINS-1:0]                  gpio_fall_en;    // falling edge enables
   input  wire [`VIU_NUM_PINS-1:0]                  gpio_clr;        // flag clear pulses
   output wire [`VIU_NUM_PINS-1:0]                  gpio_flags;      // sticky edge flags
   output wire                                      fast_interrupt_request;   // to core
   output wire                                      normal_interrupt_request; // to core
   output wire [`VIU_NUM_LINES-1:0]                 fast_pending;    // pending fast word
   output wire [`VIU_ADDR_W-1:0]                    vector_addr;     // winner's address
   output wire                                      vector_valid;    // a vectored winner exists
   output wire [`VIU_IDX_W-1:0]                     vector_line;     // winner's index

   wire [`VIU_NUM_LINES-1:0] req_sync;    // synchronised lines
   wire [`VIU_NUM_LINES-1:0] req_merged;  // lines with gpio merged
   wire [`VIU_NUM_LINES-1:0] active;      // enabled requests
   wire [`VIU_NUM_LINES-1:0] fast_act;    // enabled fast requests
   wire [`VIU_NUM_LINES-1:0] vect_act;    // enabled vectored requests
   wire                      gpio_any;    // any gpio edge flag set

   // registered outputs
   reg                       fast_q;
   reg                       normal_q;
   reg [`VIU_NUM_LINES-1:0]  fast_pend_q;
   reg [`VIU_ADDR_W-1:0]     vaddr_q;
   reg                       vvalid_q;
   reg [`VIU_IDX_W-1:0]      vline_q;

   // arbitration results
   reg                       win_found;
   reg [`VIU_IDX_W-1:0]      win_idx;
   reg [`VIU_PRIO_W-1:0]     win_prio;
   reg [`VIU_ADDR_W-1:0]     win_addr;
   integer                   i;

   // peripheral lines pass two flops; each peripheral owns one line
   viu_req_sync u_sync (
      .clk     (clk),
      .reset   (reset),
      .req_in  (irq_lines),
      .req_out (req_sync)
   );

   // one edge detector per gpio pin
   genvar g;
   generate
      for (g = 0; g < `VIU_NUM_PINS; g = g + 1) begin : g_pin
         viu_pin_edge u_edge (
            .clk     (clk),
            .reset   (reset),
            .pin     (gpio_pins[g]),
            .rise_en (gpio_rise_en[g]),
            .fall_en (gpio_fall_en[g]),
            .clr     (gpio_clr[g]),
            .flag    (gpio_flags[g])
         );
      end
   endgenerate

   // gpio edges share the external line three input, not lines of their own
   assign gpio_any   = |gpio_flags;
   assign req_merged = req_sync |
                       ({{(`VIU_NUM_LINES-1){1'b0}}, gpio_any} << `VIU_EXT3_LINE);

   // class split, gated by enables; settings are live, so changes reach the outputs at the next edge
   assign active   = req_merged & line_enable;
   assign fast_act = active & fast_select;
   assign vect_act = active & ~fast_select;

   // pick highest priority (lowest value); strict < keeps lowest channel on ties
   always @* begin
      win_found = 1'b0;
      win_idx   = {`VIU_IDX_W{1'b0}};
      win_prio  = {`VIU_PRIO_W{1'b1}};
      win_addr  = {`VIU_ADDR_W{1'b0}};
      for (i = 0; i < `VIU_NUM_LINES; i = i + 1) begin
         if (vect_act[i] &&
             (!win_found || line_prio[i*`VIU_PRIO_W +: `VIU_PRIO_W] < win_prio)) begin
            win_found = 1'b1;
            win_idx   = i[`VIU_IDX_W-1:0];
            win_prio  = line_prio[i*`VIU_PRIO_W +: `VIU_PRIO_W];
            win_addr  = line_addr[i*`VIU_ADDR_W +: `VIU_ADDR_W];
         end
      end
   end

   // register outputs to the core and the readable words
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         fast_q      <= 1'b0;
         normal_q    <= 1'b0;
         fast_pend_q <= `VIU_RST_FAST;
         vaddr_q     <= `VIU_RST_ADDR;
         vvalid_q    <= 1'b0;
         vline_q     <= {`VIU_IDX_W{1'b0}};
      end else begin
         fast_q      <= |fast_act;
         normal_q    <= |vect_act;
         fast_pend_q <= fast_act;
         vaddr_q     <= win_addr;
         vvalid_q    <= win_found;
         vline_q     <= win_idx;
      end
   end

   // fast class always has its own pin, so the core takes it first
   assign fast_interrupt_request   = fast_q;
   assign normal_interrupt_request = normal_q;
   assign fast_pending             = fast_pend_q;
   assign vector_addr              = vaddr_q;
   assign vector_valid             = vvalid_q;
   assign vector_line              = vline_q;
endmodule // viu_vectored_irq_unit

/* viu_asserts.sv */
`include "viu_regs.vh"
// ties each registered output to delayed requests and config
module viu_asserts (
   input wire logic          clk,
   input wire logic          reset,
   input wire logic [31:0]   irq_lines,
   input wire logic [31:0]   line_enable,
   input wire logic [31:0]   fast_select,
   input wire logic [1023:0] line_addr,
   input wire logic [63:0]   gpio_flags,
   input wire logic          fast_interrupt_request,
   input wire logic          normal_interrupt_request,
   input wire logic [31:0]   fast_pending,
   input wire logic [31:0]   vector_addr,
   input wire logic          vector_valid,
   input wire logic [4:0]    vector_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0]   s1_q, s2_q, s3_q, en_q, fs_q; // sync mirror, config
   logic [1023:0] ad_q;                         // addresses one edge back
   logic          gp_q;                         // gpio flags reach line 17 late
   wire  [31:0]   rq = (s3_q | {14'h0, gp_q, 17'h0}) & en_q;
   wire  [31:0]   fq = rq & fs_q;
   wire  [31:0]   vq = rq & ~fs_q;
   // reset mirror too, so a mid-run reset flushes stale requests
   always @(posedge clk or posedge reset) begin
      if (reset) {s3_q, s2_q, s1_q} <= '0;
      else {s3_q, s2_q, s1_q} <= {s2_q, s1_q, irq_lines};
   end
   always @(posedge clk) begin
      {ad_q, en_q, fs_q, gp_q} <= {line_addr, line_enable, fast_select, |gpio_flags};
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_fast; fast_interrupt_request == |fq; endproperty
   a_fast: assert property (p_fast) else $error("fast out");
   property p_norm; normal_interrupt_request == |vq; endproperty
   a_norm: assert property (p_norm) else $error("normal out");
   property p_pend; fast_pending == fq; endproperty
   a_pend: assert property (p_pend) else $error("pending word");
   property p_valid; vector_valid == |vq; endproperty
   a_valid: assert property (p_valid) else $error("valid flag");
   property p_win; vector_valid |-> vq[vector_line]; endproperty
   a_win: assert property (p_win) else $error("winner idle");
   property p_addr; vector_valid |-> vector_addr == ad_q[vector_line*32 +: 32]; endproperty
   a_addr: assert property (p_addr) else $error("vector addr");
   property p_idle; !vector_valid |-> vector_addr == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("idle addr");
   property p_ext; $rose(|gpio_flags) && line_enable[17] && !fast_select[17]
      |-> ##1 normal_interrupt_request; endproperty
   a_ext: assert property (p_ext) else $error("gpio merge");
   c_fast: cover property (fast_interrupt_request && normal_interrupt_request);
   c_vec: cover property (vector_valid && vector_addr == 32'h1024);
   c_gpio: cover property (|gpio_flags && normal_interrupt_request);
endmodule // viu_asserts

/* viu_core_model.sv */
// core side: fast entry masks normal, else branches to the vector
module viu_core_model (
   input  wire logic        clk,
   input  wire logic        fast_interrupt_request,
   input  wire logic        normal_interrupt_request,
   input  wire logic [31:0] vector_addr,
   output logic      [31:0] target
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge clk) begin
      if (fast_interrupt_request) target <= 32'hffff_fff0;
      else if (normal_interrupt_request) target <= vector_addr;
      else target <= 32'h0;
   end
endmodule // viu_core_model

/* tb_top.sv */
`include "viu_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %0t %h %h", $time, (g), (e)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [31:0] irq, en, fs; logic [4:0] ln;} viu_row_t;
   logic          clk, reset, fast_interrupt_request, normal_interrupt_request, vector_valid;
   logic [31:0]   irq_lines, line_enable, fast_select, fast_pending, vector_addr, target;
   logic [127:0]  line_prio;
   logic [1023:0] line_addr;
   logic [63:0]   gpio_pins, gpio_rise_en, gpio_fall_en, gpio_clr, gpio_flags;
   logic [4:0]    vector_line;
   int            miscompares = 0, checked = 0;
   // one whole line per peripheral in every row
   viu_row_t rows [7] = '{'{32'h8, '1, 32'h0, 5'd3}, '{32'h220, '1, 32'h0, 5'd9},
      '{32'h10_0200, '1, 32'h0, 5'd9}, '{32'h8000_0000, '1, 32'h0, 5'd31},
      '{32'h200, '1, 32'h200, 5'd0}, '{32'h10_0200, '1, 32'h200, 5'd20},
      '{32'hc, 32'hffff_fff7, 32'h4, 5'd0}};
   viu_vectored_irq_unit u_dut (.*);
   viu_core_model u_core (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // watchdog well past the expected run length
   initial begin
      #200000;
      miscompares++;
      test_done;
   end
   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic expect_out(input logic [31:0] ir, en, fs, input logic [4:0] ln);
      logic [31:0] v;
      logic [31:0] a;
      v = ir & en & ~fs;
      a = |v ? 32'h1000 + 32'(ln) * 4 : 32'h0;
      `CHK(fast_interrupt_request, |(ir & en & fs))
      `CHK(normal_interrupt_request, |v)
      `CHK(fast_pending, ir & en & fs)
      `CHK(vector_addr, a)
      if (|v) `CHK(vector_line, ln)
      `CHK(target, |(ir & en & fs) ? 32'hffff_fff0 : a)
   endtask
   initial begin
      {irq_lines, line_enable, fast_select, gpio_clr, gpio_rise_en} = {96'h0, 64'h0, 64'h1};
      {gpio_pins, gpio_fall_en} = {2{64'h100_0000_0000}};
      reset = 1'b1;
      for (int i = 0; i < 32; i++) begin
         line_prio[4*i +: 4] = (i == 9 || i == 20) ? 4'h2 : 4'h8;
         line_addr[32*i +: 32] = 32'h1000 + i * 4;
      end
      tick(6);
      reset = 1'b0;
      foreach (rows[i]) begin
         {irq_lines, line_enable, fast_select} = {rows[i].irq, rows[i].en, rows[i].fs};
         tick(5);
         expect_out(rows[i].irq, rows[i].en, rows[i].fs, rows[i].ln);
         $display("row %0d done", i);
      end
      // line 5 overtakes line 9 while both stay pending
      {irq_lines, line_enable, fast_select} = {32'h220, 32'hffff_ffff, 32'h0};
      tick(5);
      line_prio[23:20] = 4'h0;
      tick(2);
      expect_out(32'h220, '1, '0, 5'd5);
      {irq_lines, gpio_pins[0]} = {32'h0, 1'b1};
      tick(6);
      `CHK(gpio_flags, 64'h1)
      expect_out(32'h2_0000, '1, '0, 5'd17);
      {gpio_clr, gpio_pins[0]} = {64'h1, 1'b0};
      tick(1);
      gpio_clr = '0;
      tick(5);
      `CHK(gpio_flags, 64'h0)
      gpio_pins[40] = 1'b0;
      tick(6);
      `CHK(gpio_flags, 64'h100_0000_0000)
      // pin 40 now on both edges: clear it, then a rising edge must set it
      {gpio_clr[40], gpio_rise_en[40]} = 2'b11;
      tick(1);
      gpio_clr = '0;
      tick(1);
      `CHK(gpio_flags, 64'h0)
      gpio_pins[40] = 1'b1;
      tick(4);
      `CHK(gpio_flags, 64'h100_0000_0000)
      irq_lines = 32'h8;
      tick(5);
      reset = 1'b1;
      tick(2);
      `CHK({normal_interrupt_request, gpio_flags}, 65'h0)
      reset = 1'b0;
      tick(1);
      `CHK(vector_valid, 1'b0)
      tick(5);
      expect_out(32'h8, '1, '0, 5'd3);
      // pin 40 idles high with rising edges enabled: no flag after reset
      `CHK(gpio_flags, 64'h0)
      $display("hand tests done");
      test_done;
   end
endmodule // tb_top
bind viu_vectored_irq_unit viu_asserts u_chk (.*);
